// file: test/pipe_model.sv
// Purpose: core pipeline stand-in for copy requests and interrupts
// Assumes: bench commands, one clock
// Notes:   a released address is inverted so no stale value passes
`timescale 1ns/10ps
module pipe_model
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        go_move,
   input  wire logic [15:0] go_addr,
   input  wire logic        go_irq,
   input  wire logic        move_ack,
   output logic             move_req,
   output logic      [15:0] move_addr,
   output logic             irq_unmasked
);
   // =========================================================
   // copy request, held until taken
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         move_req  <= 1'b0;
         move_addr <= 16'h0000;
      end
      else if (move_req && move_ack)
      begin
         move_req  <= 1'b0;
         move_addr <= ~move_addr;
      end
      else if (go_move)
      begin
         move_req  <= 1'b1;
         move_addr <= go_addr;
      end
   end
   // =========================================================
   // pending interrupt level
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
         irq_unmasked <= 1'b0;
      else
         irq_unmasked <= go_irq;
   end
endmodule : pipe_model

// file: test/tb_acc_move_exec.sv
// Purpose: self-checking bench for the accumulator and copy executor
// Assumes: zero wait state slave, reads noted in a queue
// Notes:   copy cycle budgets are timed by counting status polls
`timescale 1ns/10ps
module tb_acc_move_exec;
   logic        clk_sys = 1'b0;
   logic        resetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic        pready;
   logic        pslverr;
   logic        move_req;
   logic [15:0] move_addr;
   logic        move_ack;
   logic        irq_unmasked;
   logic        core_halted;
   logic        periph_run;
   logic        isr_branch;
   logic        go_move = 1'b0;
   logic [15:0] go_addr = 16'h0000;
   logic        go_irq = 1'b0;
   logic [33:0] exp_q[$];
   logic [33:0] mon_e;
   logic [31:0] seed = 32'h2603;
   logic [31:0] rdat;
   logic [31:0] a;
   logic [31:0] b;
   logic [31:0] exp_pc = 32'h0;
   logic [31:0] ta[3] = '{32'h4, 32'h4, 32'hFFFFFFFD};
   logic [31:0] tb[3] = '{32'h5, 32'h4, 32'h2};
   int          n_mismatch = 0;
   int          check_count = 0;
   int          isr_n = 0;
   int          ack_n = 0;
   int          polls = 0;

   acc_move_exec acc_move_exec_inst
   (
      .clk_sys(clk_sys), .resetn(resetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .move_req(move_req), .move_addr(move_addr),
      .move_ack(move_ack), .irq_unmasked(irq_unmasked),
      .core_halted(core_halted), .periph_run(periph_run),
      .isr_branch(isr_branch)
   );
   pipe_model pipe_model_inst
   (
      .clk_sys(clk_sys), .resetn(resetn), .go_move(go_move),
      .go_addr(go_addr), .go_irq(go_irq), .move_ack(move_ack),
      .move_req(move_req), .move_addr(move_addr),
      .irq_unmasked(irq_unmasked)
   );

   always #20 clk_sys = ~clk_sys;

   // =========================================================
   // helpers
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr

   task automatic check(input string what, input logic [31:0] e,
                        input logic [31:0] g);
   begin
      check_count++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("unexpected %s: expected %h seen %h", what, e, g);
      end
   end
   endtask : check

   task automatic end_of_test();
   begin
      if (n_mismatch == 0 && check_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   end
   endtask : end_of_test

   // note layout: [33] compare data, [32] error, [31:0] data
   task automatic apb(input logic w, input logic [11:0] ad,
                      input logic [31:0] d, input logic [33:0] e);
   begin
      @(posedge clk_sys);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= w;
      paddr   <= ad;
      pwdata  <= d;
      exp_q.push_back(e);
      @(posedge clk_sys);
      penable <= 1'b1;
      @(posedge clk_sys);
      while (pready !== 1'b1)
         @(posedge clk_sys);
      rdat = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
   end
   endtask : apb

   task automatic wr(input logic [11:0] ad, input logic [31:0] d);
      apb(1'b1, ad, d, {2'b00, 32'h0});
   endtask : wr

   task automatic rd(input logic [11:0] ad, input logic [31:0] e);
      apb(1'b0, ad, 32'h0, {2'b10, e});
   endtask : rd

   task automatic issue(input logic [15:0] op);
      int i;
   begin
      wr(dsp_exec_pkg::OFF_INSTR, {16'h0000, op});
      exp_pc++;
      polls = 0;
      for (i = 0; i < 40; i++)
      begin
         polls++;
         apb(1'b0, dsp_exec_pkg::OFF_STAT, 32'h0, {2'b00, 32'h0});
         if (rdat[dsp_exec_pkg::STAT_BUSY] === 1'b0)
            break;
      end
   end
   endtask : issue

   task automatic ram(input logic [15:0] ad, input logic [15:0] v,
                      input logic chk);
   begin
      wr(dsp_exec_pkg::OFF_RADDR, {16'h0000, ad});
      if (chk)
         rd(dsp_exec_pkg::OFF_RDATA, {16'h0000, v});
      else
         wr(dsp_exec_pkg::OFF_RDATA, {16'h0000, v});
   end
   endtask : ram

   // one copy through the auxiliary pointer; ok says it must land
   task automatic mv(input logic [31:0] cfg, input logic [15:0] src,
                     input logic ok);
      logic [15:0] v;
   begin
      seed = lfsr(seed);
      v = seed[15:0];
      wr(dsp_exec_pkg::OFF_CFG, cfg);
      if (src >= 16'h0200)
         ram(src, v, 1'b0);
      ram(src + 16'h0001, ~v, 1'b0);
      wr(dsp_exec_pkg::OFF_AR, {16'h0000, src});
      issue(16'h7780);
      if (src >= 16'h0200)
         ram(src, v, 1'b1);
      ram(src + 16'h0001, ok ? v : ~v, 1'b1);
   end
   endtask : mv

   task automatic idle_wake(input logic [31:0] cfg, input int isr);
      int i;
   begin
      wr(dsp_exec_pkg::OFF_CFG, cfg);
      wr(dsp_exec_pkg::OFF_INSTR, {16'h0000, dsp_exec_pkg::OP_IDLE});
      exp_pc++;
      repeat (2) @(posedge clk_sys);
      check("core_halted", 32'h1, {31'h0, core_halted});
      check("periph_run", 32'h1, {31'h0, periph_run});
      rd(dsp_exec_pkg::OFF_PC, exp_pc);
      go_irq <= 1'b1;
      for (i = 0; i < 20 && core_halted !== 1'b0; i++)
         @(posedge clk_sys);
      go_irq <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("core_halted", 32'h0, {31'h0, core_halted});
      check("isr pulses", isr, isr_n);
   end
   endtask : idle_wake

   // =========================================================
   // monitors
   always @(posedge clk_sys)
   begin
      if (psel === 1'b1 && penable === 1'b1 && pready === 1'b1
          && exp_q.size() > 0)
      begin
         mon_e = exp_q.pop_front();
         check("pslverr", {31'h0, mon_e[32]}, {31'h0, pslverr});
         if (mon_e[33])
            check("prdata", mon_e[31:0], prdata);
      end
      if (isr_branch === 1'b1)
         isr_n++;
      if (move_req === 1'b1 && move_ack === 1'b1)
         ack_n++;
   end

   initial
   begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      end_of_test();
   end

   // =========================================================
   // main sequence
   initial
   begin
      repeat (2) @(posedge clk_sys);
      resetn <= 1'b1;
      rd(dsp_exec_pkg::OFF_ACC, 32'h0);
      rd(dsp_exec_pkg::OFF_CFG, {28'h0, dsp_exec_pkg::CFG_RST});
      rd(dsp_exec_pkg::OFF_PC, 32'h0);
      apb(1'b0, 12'h030, 32'h0, {2'b11, 32'h0});
      apb(1'b1, 12'h000, 32'h1234, {2'b01, 32'h0});
      for (int i = 0; i < 6; i++)
      begin
         seed = lfsr(seed);
         a = (i < 3) ? ta[i] : seed;
         seed = lfsr(seed);
         b = (i < 3) ? tb[i] : seed;
         wr(dsp_exec_pkg::OFF_ACC, a);
         wr(dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER, b);
         issue(dsp_exec_pkg::OP_MIN);
         rd(dsp_exec_pkg::OFF_STAT, {31'h0, $signed(a) < $signed(b)});
         if ($signed(a) < $signed(b))
            b = a;
         rd(dsp_exec_pkg::OFF_ACC, b);
         rd(dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER, b);
      end
      wr(dsp_exec_pkg::OFF_ACC, seed);
      wr(dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER, ~seed);
      issue(dsp_exec_pkg::OP_SWAP);
      rd(dsp_exec_pkg::OFF_ACC, ~seed);
      rd(dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER, seed);
      mv(32'h4, 16'h02FF, 1'b1);
      mv(32'h5, 16'h02FF, 1'b0);
      mv(32'h4, 16'h01FF, 1'b0);
      mv(32'h6, 16'h03FF, 1'b1);
      mv(32'h4, 16'h03FF, 1'b0);
      rd(dsp_exec_pkg::OFF_PC, exp_pc);
      ram(16'h0310, 16'h5A3C, 1'b0);
      ram(16'h0311, 16'h0000, 1'b0);
      go_addr <= 16'h0310;
      go_move <= 1'b1;
      @(posedge clk_sys);
      go_move <= 1'b0;
      repeat (4) @(posedge clk_sys);
      check("move acks", 32'h1, ack_n);
      ram(16'h0311, 16'h5A3C, 1'b1);
      wr(dsp_exec_pkg::OFF_RPT, 32'h2);
      wr(dsp_exec_pkg::OFF_CFG, 32'hE);
      ram(16'h0400, 16'h1111, 1'b0);
      ram(16'h0401, 16'h2222, 1'b0);
      wr(dsp_exec_pkg::OFF_AR, 32'h0401);
      issue(16'h7780);
      check("copy polls", 32'h3, polls);
      ram(16'h0402, 16'h2222, 1'b1);
      ram(16'h0401, 16'h1111, 1'b1);
      wr(dsp_exec_pkg::OFF_CFG, 32'h6);
      issue(16'h7780);
      check("copy polls", 32'h2, polls);
      ram(16'h0402, 16'h1111, 1'b1);
      idle_wake(32'h4, 0);
      idle_wake(32'h0, 1);
      repeat (2) @(posedge clk_sys);
      end_of_test();
   end
endmodule : tb_acc_move_exec

// file: verilog/acc_cmp_unit.sv
// Purpose: signed keep-smaller and swap datapath for the accumulators
// Assumes: combinational, results applied by the caller
// Notes:   uses the values presented, i.e. before the instruction
`timescale 1ns/10ps
module acc_cmp_unit
#(
   parameter int W = 32
)
(
   input  wire logic [W-1:0] acc,
   input  wire logic [W-1:0] accumulator_buffer,
   input  wire logic         do_min,
   input  wire logic         do_swap,
   output logic      [W-1:0] next_acc,
   output logic      [W-1:0] next_accumulator_buffer,
   output logic              lt
);
   always_comb
   begin
      lt        = $signed(acc) < $signed(accumulator_buffer);
      next_acc  = acc;
      next_accumulator_buffer = accumulator_buffer;
      if (do_min)
      begin
         next_acc  = lt ? acc : accumulator_buffer;
         next_accumulator_buffer = lt ? acc : accumulator_buffer;
      end
      else if (do_swap)
      begin
         next_acc  = accumulator_buffer;
         next_accumulator_buffer = acc;
      end
   end
endmodule : acc_cmp_unit

// file: verilog/acc_move_exec.sv
// Purpose: executes keep-smaller, swap, next-address copy and idle
// Assumes: APB slave, zero wait states, one clock clk_sys
// Notes:   repeated copies walk downward so a delay line shifts safely
`timescale 1ns/10ps
module acc_move_exec
#(
   parameter int RPT_W = dsp_exec_pkg::RPT_W
)
(
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        move_req,
   input  wire logic [15:0] move_addr,
   output logic             move_ack,
   input  wire logic        irq_unmasked,
   output logic             core_halted,
   output logic             periph_run,
   output logic             isr_branch
);
   localparam int AW = dsp_exec_pkg::AW;
   localparam int CW = dsp_exec_pkg::CYC_W;
   localparam int AC = dsp_exec_pkg::ACC_W;

   // =========================================================
   // state
   dsp_exec_pkg::exec_state_e    state;
   logic [AC-1:0]                acc;
   logic [AC-1:0]                accumulator_buffer;
   logic                         carry;
   logic [15:0]                  pc;
   logic [15:0]                  last_instr;
   logic [3:0]                   cfg;
   logic [dsp_exec_pkg::DP_W-1:0] dp;
   logic [AW-1:0]                ar;
   logic [RPT_W-1:0]             rpt;
   logic [AW-1:0]                raddr;
   logic [AW-1:0]                ram [dsp_exec_pkg::RAM_WORDS];
   logic [AW-1:0]                cur_addr;
   logic [RPT_W-1:0]             copies_left;
   logic [CW-1:0]                cyc;
   logic [CW-1:0]                budget;
   logic                         step_pc;
   logic                         err_q;

   // =========================================================
   // bus decode
   logic          setup;
   logic          wr;
   logic          instr_wr;
   logic          op_min;
   logic          op_swap;
   logic          op_idle;
   logic          op_move;
   logic          op_known;
   logic [AW-1:0] op_addr;
   logic [AC-1:0] cmp_acc;
   logic [AC-1:0] cmp_accumulator_buffer;
   logic          cmp_lt;
   logic          move_go;
   logic          ram_block_config_bit;
   logic          ram_overlay_bit;

   assign ram_block_config_bit      = cfg[dsp_exec_pkg::CFG_CNF];
   assign ram_overlay_bit     = cfg[dsp_exec_pkg::CFG_RAM_OVERLAY_BIT];
   assign setup    = psel && !penable;
   assign wr       = psel && penable && pwrite && !err_q;
   assign instr_wr = wr && paddr == dsp_exec_pkg::OFF_INSTR;
   assign op_min   = pwdata[15:0] == dsp_exec_pkg::OP_MIN;
   assign op_swap  = pwdata[15:0] == dsp_exec_pkg::OP_SWAP;
   assign op_idle  = pwdata[15:0] == dsp_exec_pkg::OP_IDLE;
   assign op_move  = pwdata[15:8] == dsp_exec_pkg::OP_MOVE_HI;
   assign op_known = op_min || op_swap || op_idle || op_move;
   assign op_addr  = pwdata[dsp_exec_pkg::IND_BIT] ? ar
                     : {dp, pwdata[6:0]};
   assign pready   = 1'b1;
   assign pslverr  = err_q;
   // pipeline copies only start while the bus is quiet
   assign move_go  = move_req && state == dsp_exec_pkg::S_READY
                     && !psel;
   assign move_ack = move_go;
   // peripherals are outside the halted core and never stop
   assign periph_run = 1'b1;

   acc_cmp_unit #(.W(AC)) u_cmp
   (
      .acc       (acc),
      .accumulator_buffer      (accumulator_buffer),
      .do_min    (op_min),
      .do_swap   (op_swap),
      .next_acc  (cmp_acc),
      .next_accumulator_buffer (cmp_accumulator_buffer),
      .lt        (cmp_lt)
   );

   // cycle budget of a copy run of n words
   function automatic logic [CW-1:0] move_budget(
      input logic [RPT_W-1:0] n,
      input logic [AW-1:0]    a,
      input logic             code_sa);
      logic [CW-1:0] nn;
   begin
      nn = CW'(n);
      if (a >= dsp_exec_pkg::OVLB_LO && a <= dsp_exec_pkg::OVLB_HI)
      begin
         if (code_sa)
            move_budget = CW'(2 * nn + 1);
         else if (nn > CW'(1))
            move_budget = CW'(2 * nn - 2);
         else
            move_budget = CW'(1);
      end
      else
         move_budget = nn;
   end
   endfunction : move_budget

   // =========================================================
   // read data and error, sampled in the setup cycle
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         prdata <= 32'h0000_0000;
         err_q  <= 1'b0;
      end
      else if (setup)
      begin
         err_q  <= 1'b0;
         prdata <= 32'h0000_0000;
         if (paddr == dsp_exec_pkg::OFF_INSTR)
         begin
            prdata <= {16'h0000, last_instr};
            err_q  <= pwrite && (state != dsp_exec_pkg::S_READY
                      || !op_known);
         end
         else if (paddr == dsp_exec_pkg::OFF_ACC)
            prdata <= acc;
         else if (paddr == dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER)
            prdata <= accumulator_buffer;
         else if (paddr == dsp_exec_pkg::OFF_CFG)
            prdata <= {28'h0000000, cfg};
         else if (paddr == dsp_exec_pkg::OFF_STAT)
            prdata <= {29'h00000000,
                       state == dsp_exec_pkg::S_IDLE,
                       state == dsp_exec_pkg::S_EXEC, carry};
         else if (paddr == dsp_exec_pkg::OFF_PC)
            prdata <= {16'h0000, pc};
         else if (paddr == dsp_exec_pkg::OFF_DP)
            prdata <= {23'h000000, dp};
         else if (paddr == dsp_exec_pkg::OFF_AR)
            prdata <= {16'h0000, ar};
         else if (paddr == dsp_exec_pkg::OFF_RPT)
            prdata <= {{(32-RPT_W){1'b0}}, rpt};
         else if (paddr == dsp_exec_pkg::OFF_RADDR)
            prdata <= {16'h0000, raddr};
         else if (paddr == dsp_exec_pkg::OFF_RDATA)
            prdata <= {16'h0000, ram[dsp_exec_pkg::ram_idx(raddr)]};
         else
            err_q <= 1'b1;
      end
   end

   // =========================================================
   // software-written configuration
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         cfg   <= dsp_exec_pkg::CFG_RST;
         dp    <= '0;
         ar    <= '0;
         rpt   <= '0;
         raddr <= '0;
      end
      else if (wr)
      begin
         if (paddr == dsp_exec_pkg::OFF_CFG)
            cfg <= pwdata[3:0];
         else if (paddr == dsp_exec_pkg::OFF_DP)
            dp <= pwdata[dsp_exec_pkg::DP_W-1:0];
         else if (paddr == dsp_exec_pkg::OFF_AR)
            ar <= pwdata[AW-1:0];
         else if (paddr == dsp_exec_pkg::OFF_RPT)
            rpt <= pwdata[RPT_W-1:0];
         else if (paddr == dsp_exec_pkg::OFF_RADDR)
            raddr <= pwdata[AW-1:0];
      end
   end

   // =========================================================
   // accumulators and carry
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         acc   <= '0;
         accumulator_buffer  <= '0;
         carry <= 1'b0;
      end
      else if (instr_wr && (op_min || op_swap))
      begin
         acc  <= cmp_acc;
         accumulator_buffer <= cmp_accumulator_buffer;
         if (op_min)
            carry <= cmp_lt;
      end
      else if (wr && paddr == dsp_exec_pkg::OFF_ACC)
         acc <= pwdata;
      else if (wr && paddr == dsp_exec_pkg::OFF_ACCUMULATOR_BUFFER)
         accumulator_buffer <= pwdata;
   end

   // =========================================================
   // copy engine: read source, write source+1 when both are data
   logic [AW-1:0] src;
   logic [AW-1:0] dst;
   logic          copy_on;
   logic          copy_we;
   logic [AW-1:0] copy_data;

   assign src       = move_go ? move_addr : cur_addr;
   assign dst       = src + 16'h0001;
   assign copy_on   = move_go || (state == dsp_exec_pkg::S_EXEC
                      && copies_left != '0);
   assign copy_data = ram[dsp_exec_pkg::ram_idx(src)];
   assign copy_we   = copy_on
                      && dsp_exec_pkg::in_data(src, ram_block_config_bit, ram_overlay_bit)
                      && dsp_exec_pkg::in_data(dst, ram_block_config_bit, ram_overlay_bit);

   // a copy writes only the destination word; bus writes to RDATA write ram at raddr unless a copy writes in the same cycle
   always_ff @(posedge clk_sys)
   begin
      if (copy_we)
         ram[dsp_exec_pkg::ram_idx(dst)] <= copy_data;
      else if (wr && paddr == dsp_exec_pkg::OFF_RDATA)
         ram[dsp_exec_pkg::ram_idx(raddr)] <= pwdata[AW-1:0];
   end

   // =========================================================
   // sequencer
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         state       <= dsp_exec_pkg::S_READY;
         cur_addr    <= '0;
         copies_left <= '0;
         cyc         <= '0;
         budget      <= '0;
         isr_branch  <= 1'b0;
      end
      else
      begin
         isr_branch <= 1'b0;
         case (state)
            dsp_exec_pkg::S_READY:
            begin
               if (instr_wr && op_idle)
                  state <= dsp_exec_pkg::S_IDLE;
               else if (instr_wr && op_move)
               begin
                  state       <= dsp_exec_pkg::S_EXEC;
                  cur_addr    <= op_addr;
                  copies_left <= (rpt == '0) ? RPT_W'(1) : rpt;
                  budget      <= move_budget((rpt == '0) ? RPT_W'(1)
                                 : rpt, op_addr,
                                 cfg[dsp_exec_pkg::CFG_CODE_SA]);
                  cyc         <= '0;
               end
            end
            dsp_exec_pkg::S_EXEC:
            begin
               if (copies_left != '0)
               begin
                  copies_left <= copies_left - RPT_W'(1);
                  cur_addr    <= cur_addr - 16'h0001;
               end
               cyc <= cyc + CW'(1);
               if (cyc + CW'(1) >= budget)
                  state <= dsp_exec_pkg::S_READY;
            end
            dsp_exec_pkg::S_IDLE:
            begin
               if (irq_unmasked)
               begin
                  state      <= dsp_exec_pkg::S_READY;
                  isr_branch <= !cfg[dsp_exec_pkg::CFG_GLOBAL_INTERRUPT_MASK];
               end
            end
            default:
               state <= dsp_exec_pkg::S_READY;
         endcase
      end
   end

   // =========================================================
   // program counter and halt flag
   always_ff @(posedge clk_sys or negedge resetn)
   begin
      if (!resetn)
      begin
         pc          <= '0;
         last_instr  <= '0;
         core_halted <= 1'b0;
      end
      else
      begin
         if (instr_wr)
         begin
            pc         <= pc + 16'h0001;
            last_instr <= pwdata[15:0];
         end
         else if (wr && paddr == dsp_exec_pkg::OFF_PC)
            pc <= pwdata[15:0];
         core_halted <= (instr_wr && op_idle) ||
                        (state == dsp_exec_pkg::S_IDLE && !irq_unmasked);
      end
   end

   // =========================================================
   // checks
   default clocking ck @(posedge clk_sys); endclocking
   default disable iff (!resetn);

   logic [AC-1:0] p_acc;
   logic [AC-1:0] p_accumulator_buffer;
   always_ff @(posedge clk_sys)
   begin
      p_acc  <= acc;
      p_accumulator_buffer <= accumulator_buffer;
   end

   min_value_a: assert property (instr_wr && op_min |=>
      acc == accumulator_buffer && ($signed(p_acc) < $signed(p_accumulator_buffer)
      ? acc == p_acc : acc == p_accumulator_buffer))
      else $error("keep-smaller result wrong");
   min_carry_a: assert property (instr_wr && op_min |=>
      carry == ($signed(p_acc) < $signed(p_accumulator_buffer)))
      else $error("keep-smaller carry wrong");
   swap_value_a: assert property (instr_wr && op_swap |=>
      acc == p_accumulator_buffer && accumulator_buffer == p_acc)
      else $error("swap did not exchange");
   pc_step_a: assert property (instr_wr |=>
      pc == $past(pc) + 16'h0001)
      else $error("pc did not step by one");
   copy_dest_a: assert property (copy_we |=>
      ram[dsp_exec_pkg::ram_idx($past(dst))] == $past(copy_data))
      else $error("copy destination wrong");
   copy_guard_a: assert property (copy_on && !wr
      && !dsp_exec_pkg::in_data(src, ram_block_config_bit, ram_overlay_bit)
      && dsp_exec_pkg::in_data(dst, ram_block_config_bit, ram_overlay_bit) |=>
      ram[dsp_exec_pkg::ram_idx($past(dst))]
      == $past(ram[dsp_exec_pkg::ram_idx(dst)]))
      else $error("write outside data ram");
   move_len_a: assert property (state == dsp_exec_pkg::S_EXEC
      && cyc + CW'(1) < budget |=> state == dsp_exec_pkg::S_EXEC)
      else $error("copy run ended early");
   idle_hold_a: assert property (state == dsp_exec_pkg::S_IDLE
      && !irq_unmasked |=> state == dsp_exec_pkg::S_IDLE && pc == $past(pc))
      else $error("idle left without interrupt");
   idle_wake_a: assert property (state == dsp_exec_pkg::S_IDLE
      && irq_unmasked |=> state == dsp_exec_pkg::S_READY
      && isr_branch == !cfg[dsp_exec_pkg::CFG_GLOBAL_INTERRUPT_MASK])
      else $error("wake from idle wrong");

   cov_min: cover property (instr_wr && op_min && cmp_lt);
   cov_run: cover property (state == dsp_exec_pkg::S_EXEC
      && copies_left > RPT_W'(1));
   cov_wake: cover property (isr_branch);
   cov_pipe: cover property (move_go && copy_we);
endmodule : acc_move_exec

// file: verilog/dsp_exec_pkg.sv
// Purpose: constants shared by the accumulator and data-move executor
// Assumes: 32-bit APB register map, 16-bit data addresses
// Notes:   block bounds and register offsets live only here
package dsp_exec_pkg;
   // =========================================================
   // widths
   localparam int ACC_W  = 32;
   localparam int AW     = 16;
   localparam int DP_W   = 9;
   localparam int RPT_W  = 8;
   localparam int CYC_W  = 10;
   localparam int RAM_IW = 10;
   localparam int RAM_WORDS = 768;
   // =========================================================
   // register offsets (byte addresses)
   localparam logic [11:0] OFF_INSTR = 12'h000;
   localparam logic [11:0] OFF_ACC   = 12'h004;
   localparam logic [11:0] OFF_ACCUMULATOR_BUFFER  = 12'h008;
   localparam logic [11:0] OFF_CFG   = 12'h00C;
   localparam logic [11:0] OFF_STAT  = 12'h010;
   localparam logic [11:0] OFF_PC    = 12'h014;
   localparam logic [11:0] OFF_DP    = 12'h018;
   localparam logic [11:0] OFF_AR    = 12'h01C;
   localparam logic [11:0] OFF_RPT   = 12'h020;
   localparam logic [11:0] OFF_RADDR = 12'h024;
   localparam logic [11:0] OFF_RDATA = 12'h028;
   // =========================================================
   // opcodes
   localparam logic [15:0] OP_MIN  = 16'hBE1B;
   localparam logic [15:0] OP_SWAP = 16'hBE1D;
   localparam logic [15:0] OP_IDLE = 16'hBE22;
   localparam logic [7:0]  OP_MOVE_HI = 8'h77;
   localparam int          IND_BIT = 7;
   // =========================================================
   // config and status bits
   localparam int CFG_CNF  = 0;
   localparam int CFG_RAM_OVERLAY_BIT = 1;
   localparam int CFG_GLOBAL_INTERRUPT_MASK = 2;
   localparam int CFG_CODE_SA = 3;
   localparam logic [3:0] CFG_RST = 4'h4;
   localparam int STAT_CARRY = 0;
   localparam int STAT_BUSY  = 1;
   localparam int STAT_IDLE  = 2;
   // =========================================================
   // on-chip data blocks, contiguous
   localparam logic [15:0] CFGB_LO = 16'h0200;
   localparam logic [15:0] CFGB_HI = 16'h02FF;
   localparam logic [15:0] FIXB_LO = 16'h0300;
   localparam logic [15:0] FIXB_HI = 16'h03FF;
   localparam logic [15:0] OVLB_LO = 16'h0400;
   localparam logic [15:0] OVLB_HI = 16'h04FF;
   // =========================================================
   typedef enum logic [2:0]
   {
      S_READY = 3'h1,
      S_EXEC  = 3'h2,
      S_IDLE  = 3'h4
   } exec_state_e;

   // true when the address is on-chip data ram under this mapping
   function automatic logic in_data(input logic [15:0] a,
                                    input logic ram_block_config_bit,
                                    input logic ram_overlay_bit);
   begin
      in_data = (a >= FIXB_LO && a <= FIXB_HI) ||
                (!ram_block_config_bit && a >= CFGB_LO && a <= CFGB_HI) ||
                (ram_overlay_bit && a >= OVLB_LO && a <= OVLB_HI);
   end
   endfunction : in_data

   function automatic logic [RAM_IW-1:0] ram_idx(input logic [15:0] a);
      logic [15:0] d;
   begin
      d = a - CFGB_LO;
      ram_idx = d[RAM_IW-1:0];
   end
   endfunction : ram_idx
endpackage : dsp_exec_pkg
